// *** hw/call_return_reset_exec.sv ***
// Purpose: Executes relative call, software reset, interrupt and literal return
// Assumes: Instruction word valid from Q1 of its cycle; Q phases follow clock
// Notes:   Second cycle of two-cycle instructions is a forced no-operation
`include "flow_exec_defines.svh"
`default_nettype none

module call_return_reset_exec (
    // Clock and reset
    input  wire logic               mclk_in,
    input  wire logic               rst_in,
    // Program memory
    input  wire logic [15:0]        instr_in,
    // Interrupt priority mode: 1 selects high/low priority enables
    input  wire logic               prio_mode_in,
    input  wire logic               int_high_active_in,
    // Shadow registers captured by the interrupt logic
    input  wire logic [7:0]         working_shadow_in,
    input  wire logic [7:0]         status_shadow_in,
    input  wire logic [3:0]         bank_select_shadow_in,
    // Core state
    output flow_exec_pkg::pc_t      pc_out,
    output flow_exec_pkg::qphase_t  qphase_out,
    output logic [7:0]              working_out,
    output logic [7:0]              status_out,
    output logic [3:0]              bank_select_reg_out,
    output logic [7:0]              pc_high_latch_out,
    output logic [7:0]              pc_upper_latch_out,
    output logic                    high_prio_global_int_enable_out,
    output logic                    low_prio_global_int_enable_out,
    output flow_exec_pkg::pc_t      return_stack_top_out,
    output logic [`STK_PTR_W-1:0]   stack_depth_out,
    output logic                    sw_reset_out
);
    import flow_exec_pkg::*;

    qphase_t   q_r;
    op_kind_t  op_r;
    logic      flush_r;
    logic      shadow_r;
    logic [7:0] lit_r;
    pc_t       pc_r;
    pc_t       tgt_r;
    logic [7:0] w_r;
    logic [7:0] st_r;
    logic [3:0] bank_r;
    logic      hi_en_r;
    logic      lo_en_r;
    logic      swrst_r;
    logic      push;
    logic      pop;
    pc_t       stack_top;
    op_kind_t  dec;

    // ------------------------------------------------------------
    // Opcode decode
    // ------------------------------------------------------------
    function automatic op_kind_t decode_op(input logic [15:0] iw);
        if (iw[15:11] == `REL_CALL_PFX)      return OP_REL_CALL;
        else if (iw == `SWRESET_OP)          return OP_SWRST;
        else if (iw[15:1] == `IRET_PFX)      return OP_IRET;
        else if (iw[15:8] == `LRET_PFX)      return OP_LRET;
        else                                 return OP_NONE;
    endfunction : decode_op

    assign dec = flush_r ? OP_NONE : decode_op(instr_in);

    // ------------------------------------------------------------
    // Q phase sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (rst_in || swrst_r) begin
            q_r <= Q1;
        end else begin
            unique case (q_r)
                Q1: q_r <= Q2;
                Q2: q_r <= Q3;
                Q3: q_r <= Q4;
                Q4: q_r <= Q1;
            endcase
        end
    end

    // Latch decoded operation and operands in Q1
    always_ff @(posedge mclk_in) begin
        if (rst_in || swrst_r) begin
            op_r     <= OP_NONE;
            shadow_r <= 1'b0;
            lit_r    <= 8'h00;
        end else if (q_r == Q1) begin
            op_r     <= dec;
            shadow_r <= instr_in[0];
            lit_r    <= instr_in[7:0];
        end
    end

    // Second cycle of a two-cycle instruction does nothing
    always_ff @(posedge mclk_in) begin
        if (rst_in || swrst_r) begin
            flush_r <= 1'b0;
        end else if (q_r == Q4) begin
            flush_r <= (op_r == OP_REL_CALL) || (op_r == OP_IRET) || (op_r == OP_LRET);
        end
    end

    // ------------------------------------------------------------
    // Return stack
    // ------------------------------------------------------------
    // push before PC change
    assign push = (q_r == Q2) && (op_r == OP_REL_CALL);
    assign pop  = (q_r == Q4) && ((op_r == OP_IRET) || (op_r == OP_LRET));

    flow_return_stack u_stack (
        .mclk_in      (mclk_in),
        .rst_in       (rst_in || swrst_r),
        .push_in      (push),
        .pop_in       (pop),
        .push_data_in (pc_r),
        .top_out      (stack_top),
        .depth_out    (stack_depth_out)
    );

    // ------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------
    // target uses word offset
    always_ff @(posedge mclk_in) begin
        if (rst_in || swrst_r) begin
            tgt_r <= `PC_RST;
        end else if (q_r == Q2) begin
            tgt_r <= pc_r + {{9{instr_in[10]}}, instr_in[10:0], 1'b0};
        end
    end

    // pc_r already holds the incremented address during execution
    always_ff @(posedge mclk_in) begin
        if (rst_in || swrst_r) begin
            pc_r <= `PC_RST;
        end else if (q_r == Q4) begin
            unique case (op_r)
                OP_REL_CALL: pc_r <= tgt_r;
                OP_IRET, OP_LRET: pc_r <= stack_top;
                default: pc_r <= flush_r ? pc_r : pc_r + `PC_STEP;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Working, status and bank registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (rst_in || swrst_r) begin
            w_r   <= `W_RST;
            st_r  <= `STATUS_RST;
            bank_r <= `BSR_RST;
        end else if (q_r == Q4) begin
            if (op_r == OP_IRET && shadow_r) begin
                w_r   <= working_shadow_in;
                st_r  <= status_shadow_in;
                bank_r <= bank_select_shadow_in;
            end else if (op_r == OP_LRET) begin
                w_r <= lit_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Global interrupt enables
    // ------------------------------------------------------------
    // set one enable
    always_ff @(posedge mclk_in) begin
        if (rst_in || swrst_r) begin
            hi_en_r <= 1'b0;
            lo_en_r <= 1'b0;
        end else if (q_r == Q4 && op_r == OP_IRET) begin
            if (!prio_mode_in || int_high_active_in) begin
                hi_en_r <= 1'b1;
            end else begin
                lo_en_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Software reset
    // ------------------------------------------------------------
    // reset starts in Q2
    always_ff @(posedge mclk_in) begin
        if (rst_in || swrst_r) begin
            swrst_r <= 1'b0;
        end else begin
            swrst_r <= (q_r == Q2) && (op_r == OP_SWRST);
        end
    end

    assign pc_high_latch_out  = 8'h00;
    assign pc_upper_latch_out = 8'h00;

    assign pc_out                          = pc_r;
    assign qphase_out                      = q_r;
    assign working_out                     = w_r;
    assign status_out                      = st_r;
    assign bank_select_reg_out             = bank_r;
    assign high_prio_global_int_enable_out = hi_en_r;
    assign low_prio_global_int_enable_out  = lo_en_r;
    assign return_stack_top_out            = stack_top;
    assign sw_reset_out                    = swrst_r;
endmodule : call_return_reset_exec

`default_nettype wire

// *** hw/flow_exec_defines.svh ***
// Purpose: Constants for the call/return/reset execution block
// Assumes: 21-bit byte program counter, 31-entry return stack
// Notes:   Included by the package and the design files
`ifndef FLOW_EXEC_DEFINES_SVH
`define FLOW_EXEC_DEFINES_SVH

`define PC_W            21
`define STK_DEPTH       31
`define STK_PTR_W       5
// Opcode patterns
`define REL_CALL_PFX    5'h1b
`define SWRESET_OP      16'h00ff
`define IRET_PFX        15'h0008
`define LRET_PFX        8'h0c
// Program counter step for one instruction word
`define PC_STEP         21'h000002
// Reset values
`define PC_RST          21'h000000
`define W_RST           8'h00
`define STATUS_RST      8'h00
`define BSR_RST         4'h0
`define PTR_RST         5'h00

`endif

// *** hw/flow_exec_pkg.sv ***
// Purpose: Types for the call/return/reset execution block
// Assumes: flow_exec_defines.svh holds the numbers
// Notes:   Quadrature phase and decoded operation types
`include "flow_exec_defines.svh"
`default_nettype none

package flow_exec_pkg;
    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} qphase_t;
    typedef enum logic [2:0] {OP_NONE, OP_REL_CALL, OP_SWRST, OP_IRET, OP_LRET} op_kind_t;
    typedef logic [`PC_W-1:0] pc_t;
endpackage : flow_exec_pkg

`default_nettype wire

// *** hw/flow_return_stack.sv ***
// Purpose: Return address stack with push and pop
// Assumes: Push and pop never in the same cycle
// Notes:   Top entry is presented combinationally
`include "flow_exec_defines.svh"
`default_nettype none

module flow_return_stack (
    // Clock and reset
    input  wire logic               mclk_in,
    input  wire logic               rst_in,
    // Stack operations
    input  wire logic               push_in,
    input  wire logic               pop_in,
    input  wire flow_exec_pkg::pc_t push_data_in,
    output flow_exec_pkg::pc_t      top_out,
    output logic [`STK_PTR_W-1:0]   depth_out
);
    import flow_exec_pkg::*;

    pc_t                   mem_r [`STK_DEPTH+1];
    logic [`STK_PTR_W-1:0] ptr_r;

    // ------------------------------------------------------------
    // Pointer and storage
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ptr_r <= `PTR_RST;
        end else if (push_in && ptr_r != `STK_PTR_W'(`STK_DEPTH)) begin
            ptr_r <= ptr_r + 5'h01;
        end else if (pop_in && ptr_r != `PTR_RST) begin
            ptr_r <= ptr_r - 5'h01;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (push_in && ptr_r != `STK_PTR_W'(`STK_DEPTH)) begin
            mem_r[ptr_r + 5'h01] <= push_data_in;
        end
    end

    assign top_out   = (ptr_r == `PTR_RST) ? `PC_RST : mem_r[ptr_r];
    assign depth_out = ptr_r;
endmodule : flow_return_stack

`default_nettype wire

// *** verif/prog_word_model.sv ***
// Purpose: Program memory word source for the execution block
// Assumes: The core samples the word at its Q1 and Q2 edges
// Notes:   Outside those phases the bus shows a changing pattern
`default_nettype none
module prog_word_model (
    // Core side
    input  wire logic                   mclk_in,
    input  wire flow_exec_pkg::qphase_t qphase_in,
    input  wire logic [15:0]            word_in,
    output logic [15:0]                 instr_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import flow_exec_pkg::*;
    logic [15:0] junk_r = 16'h0000;
    always_ff @(posedge mclk_in) begin
        junk_r <= junk_r + 16'h1357;
    end
    assign instr_out = (qphase_in inside {Q1, Q2}) ? word_in : ~word_in ^ junk_r;
endmodule : prog_word_model
`default_nettype wire

// *** verif/flow_exec_sva.sv ***
// Purpose: Port checks for call_return_reset_exec
// Assumes: Bound from tb; one clock, reset active high
// Notes:   Software reset clears state one edge after its pulse
`include "flow_exec_defines.svh"
`default_nettype none
module flow_exec_sva (
    // Clock and reset
    input wire logic                   mclk_in,
    input wire logic                   rst_in,
    // Core state
    input wire flow_exec_pkg::pc_t     pc_out,
    input wire flow_exec_pkg::qphase_t qphase_out,
    input wire logic [7:0]             working_out,
    input wire logic [7:0]             pc_high_latch_out,
    input wire logic [7:0]             pc_upper_latch_out,
    input wire logic                   high_prio_global_int_enable_out,
    input wire logic                   low_prio_global_int_enable_out,
    input wire flow_exec_pkg::pc_t     return_stack_top_out,
    input wire logic [`STK_PTR_W-1:0]  stack_depth_out,
    input wire logic                   sw_reset_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import flow_exec_pkg::*;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    sequence s_after_q4;
        $past(qphase_out) == Q4;
    endsequence
    sequence s_cleared;
        pc_out == `PC_RST && working_out == `W_RST && stack_depth_out == `PTR_RST
            && qphase_out == Q1;
    endsequence
    a_push_in_q2: assert property (
        stack_depth_out > $past(stack_depth_out) |->
            $past(qphase_out) == Q2 && return_stack_top_out == $past(pc_out))
        else $error("push timing or value wrong");
    a_pop_in_q4: assert property (
        stack_depth_out < $past(stack_depth_out) && !$past(sw_reset_out) |->
            s_after_q4 ##0 pc_out == $past(return_stack_top_out))
        else $error("pop timing or value wrong");
    a_swreset_clears: assert property (
        $rose(sw_reset_out) |-> $past(qphase_out) == Q2 ##1 s_cleared)
        else $error("software reset wrong");
    a_pc_in_q4: assert property (
        $changed(pc_out) && !$past(sw_reset_out) |-> s_after_q4) else $error("pc moved early");
    a_w_in_q4: assert property (
        $changed(working_out) && !$past(sw_reset_out) |-> s_after_q4) else $error("w moved early");
    a_enable_in_q4: assert property (
        $rose(high_prio_global_int_enable_out) || $rose(low_prio_global_int_enable_out)
            |-> s_after_q4) else $error("enable set early");
    a_enable_sticky: assert property (
        $fell(high_prio_global_int_enable_out) || $fell(low_prio_global_int_enable_out)
            |-> $past(sw_reset_out)) else $error("enable cleared");
    a_latch_fixed: assert property (
        pc_high_latch_out == 8'h00 && pc_upper_latch_out == 8'h00) else $error("latch changed");
endmodule : flow_exec_sva
`default_nettype wire

// *** verif/tb.sv ***
// Purpose: Self-checking bench for call_return_reset_exec
// Assumes: Words driven at falling edges, one per instruction cycle
// Notes:   Expected stack kept in a queue
`include "flow_exec_defines.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import flow_exec_pkg::*;
    logic        mclk_in = 1'b0, rst_in = 1'b1, prio = 1'b0, hsel = 1'b0;
    logic [15:0] word = 16'h0000, instr;
    logic [7:0]  wsh = 8'h00, ss = 8'h00, w, st, plh, plu, wx, sx;
    logic [3:0]  bs = 4'h0, bank, bx;
    logic        gh, gl, swr, ghx, glx;
    pc_t         pc, top, pq;
    qphase_t     qph;
    logic [`STK_PTR_W-1:0] dep;
    pc_t         stk[$];
    int          mismatches = 0, compares = 0;
    always #2.5 mclk_in = ~mclk_in;
    call_return_reset_exec dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .instr_in(instr),
        .prio_mode_in(prio), .int_high_active_in(hsel), .working_shadow_in(wsh),
        .status_shadow_in(ss), .bank_select_shadow_in(bs), .pc_out(pc), .qphase_out(qph),
        .working_out(w), .status_out(st), .bank_select_reg_out(bank), .pc_high_latch_out(plh),
        .pc_upper_latch_out(plu), .high_prio_global_int_enable_out(gh),
        .low_prio_global_int_enable_out(gl), .return_stack_top_out(top),
        .stack_depth_out(dep), .sw_reset_out(swr));
    prog_word_model mem_u (.mclk_in(mclk_in), .qphase_in(qph), .word_in(word), .instr_out(instr));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic finish_test();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    task automatic issue(input logic [15:0] wd);
        for (int n = 0; n < 8 && qph !== Q1; n++) @(negedge mclk_in);
        word = wd;
        @(negedge mclk_in);
        pq = pc;
    endtask : issue
    // Second slot offers a literal return that must be ignored
    task automatic op(input logic [15:0] wd);
        issue(wd);
        repeat (3) @(negedge mclk_in);
        word = 16'h0c5a;
        repeat (3) @(negedge mclk_in);
        word = 16'h0000;
        @(negedge mclk_in);
    endtask : op
    task automatic t_call(input logic [10:0] n);
        op({`REL_CALL_PFX, n});
        stk.push_back(pq);
        chk("call pc", pc_t'(pq + {{9{n[10]}}, n, 1'b0}), pc);
        chk("call top", pq, top);
        chk("call depth", stk.size(), dep);
        chk("slot w", wx, w);
    endtask : t_call
    task automatic t_lret(input logic [7:0] k);
        op({`LRET_PFX, k});
        wx = k;
        chk("lret pc", stk.pop_back(), pc);
        chk("lret w", wx, w);
        chk("new top", stk.size() ? stk[$] : 21'h0, top);
    endtask : t_lret
    task automatic t_iret(input bit s, input bit mode, input bit hi);
        prio = mode;
        hsel = hi;
        wsh = s ? 8'h5a : 8'h3c;
        ss = s ? 8'h96 : 8'hc3;
        bs = s ? 4'h6 : 4'h9;
        ghx = ghx | !mode | hi;
        glx = glx | (mode & !hi);
        op({`IRET_PFX, s});
        if (s) begin
            {wx, sx, bx} = {wsh, ss, bs};
        end
        chk("iret pc", stk.pop_back(), pc);
        chk("enables", {ghx, glx}, {gh, gl});
        chk("w st bank", {wx, sx, bx}, {w, st, bank});
        chk("latches", 16'h0, {plh, plu});
        chk("iret depth", stk.size(), dep);
    endtask : t_iret
    task automatic t_swreset();
        issue(`SWRESET_OP);
        @(negedge mclk_in);
        chk("sw pulse", 1'b1, swr);
        word = 16'h0000;
        @(negedge mclk_in);
        chk("cleared", 0, {pc, w, st, bank, dep, gh, gl, qph});
        stk.delete();
        {wx, sx, bx, ghx, glx} = '0;
    endtask : t_swreset
    initial begin
        {wx, sx, bx, ghx, glx} = '0;
        repeat (12) @(negedge mclk_in);
        rst_in = 1'b0;
        chk("reset", 0, {pc, w, st, bank, dep, gh, gl, qph});
        t_call(11'h3ff);
        t_call(11'h400);
        t_call(11'h001);
        t_lret(8'hff);
        t_lret(8'h00);
        t_call(11'h7ff);
        t_iret(1'b0, 1'b1, 1'b0);
        t_call(11'h005);
        t_iret(1'b1, 1'b0, 1'b0);
        t_call(11'h010);
        t_swreset();
        t_call(11'h002);
        t_iret(1'b0, 1'b1, 1'b1);
        finish_test();
    end
    initial begin
        #2000;
        mismatches++;
        finish_test();
    end
endmodule : tb
bind call_return_reset_exec flow_exec_sva chk_u (.mclk_in(mclk_in), .rst_in(rst_in),
    .pc_out(pc_out), .qphase_out(qphase_out), .working_out(working_out),
    .pc_high_latch_out(pc_high_latch_out), .pc_upper_latch_out(pc_upper_latch_out),
    .high_prio_global_int_enable_out(high_prio_global_int_enable_out),
    .low_prio_global_int_enable_out(low_prio_global_int_enable_out),
    .return_stack_top_out(return_stack_top_out), .stack_depth_out(stack_depth_out),
    .sw_reset_out(sw_reset_out));
`default_nettype wire
